// file: clkref_pkg.sv
// Constants, types and helper functions shared by the clock and reference control block.
package clkref_pkg;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] CLK_CTRL_OFS  = 8'h00;
	localparam logic [7:0] FBDIV_INT_OFS = 8'h04;
	localparam logic [7:0] FRAC_TOP_OFS  = 8'h08;
	localparam logic [7:0] FRAC_BOT_OFS  = 8'h0c;
	localparam logic [7:0] REF_CTRL_OFS  = 8'h10;
	localparam logic [7:0] SUBSYS_EN_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS    = 8'h18;

	// Field positions.
	localparam int MODE_LSB     = 0;
	localparam int PREDIV_LSB   = 2;
	localparam int RATE_BIT     = 5;
	localparam int ACTIVE_BIT   = 0;
	localparam int FAST_BIT     = 1;
	localparam int BIAS_BIT     = 2;
	localparam int IOLV_BIT     = 3;
	localparam int NUM_SUBSYS   = 4;
	localparam int SYNC_W       = 2;
	localparam int LOCK_IDX     = 1;
	localparam int MCLK_IDX     = 0;

	// Values after reset.
	localparam logic [5:0] CLK_CTRL_RST  = 6'h00;
	localparam logic [6:0] FBDIV_INT_RST = 7'h20;
	localparam logic [4:0] FRAC_TOP_RST  = 5'h00;
	localparam logic [7:0] FRAC_BOT_RST  = 8'h00;
	localparam logic [3:0] REF_CTRL_RST  = 4'h4;
	localparam logic [7:0] SUBSYS_EN_RST = 8'h00;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Reference start-up timing.
	localparam int CLK_PERIOD_PS      = 5000;
	localparam int VREF_SETTLE_NS     = 10000;
	localparam int VREF_SETTLE_CYCLES = (VREF_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TIMER_W            = 12;

	typedef enum logic [1:0] {
		MODE_BYPASS = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_TRACK  = 2'b10,
		MODE_UNDEF  = 2'b11
	} pll_mode_type;

	typedef enum logic [1:0] {
		REF_STANDBY  = 2'b00,
		REF_CHARGING = 2'b01,
		REF_READY    = 2'b10
	} ref_state_type;

	// One register write handed from the bus slave to the register file.
	typedef struct packed {
		logic        valid;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_cmd_type;

	// Returns true for an aligned offset that holds a register.
	function automatic logic reg_mapped(input logic [7:0] addr);
		reg_mapped = (addr[1:0] == 2'h0) && (addr <= STATUS_OFS);
	endfunction : reg_mapped

	// Maps the predivide code to its divide factor; codes above 100 clamp to 16.
	function automatic logic [4:0] predivide_factor(input logic [2:0] code);
		predivide_factor = (code > 3'h4) ? 5'h10 : 5'(5'h01 << code);
	endfunction : predivide_factor

endpackage : clkref_pkg

// file: input_sync3.sv
// Three-stage synchroniser whose output moves only when the last two stages agree.
`timescale 1ns/1ps
module input_sync3
	import clkref_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Asynchronous inputs and filtered result
	input  wire logic [SYNC_W-1:0] async_in,
	output logic      [SYNC_W-1:0] sync_out
);

	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q     <= '0;
			s2_q     <= '0;
			s3_q     <= '0;
			sync_out <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < SYNC_W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_out[i] <= s3_q[i];
				end
			end
		end
	end

endmodule : input_sync3

// file: axil_slave.sv
// AXI4-Lite slave front end that turns bus traffic into register write pulses and read lookups.
`timescale 1ns/1ps
module axil_slave
	import clkref_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Register file side
	output wr_cmd_type       wr_cmd,
	input  wire logic [31:0] rd_data
);

	logic       aw_hold_q;
	logic       w_hold_q;
	wr_cmd_type pend_q;

	// Address and data are taken in either order and joined before the write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			pend_q    <= '0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
			wr_cmd    <= '0;
		end else begin
			wr_cmd.valid <= 1'b0;
			if (awvalid && awready) begin
				aw_hold_q   <= 1'b1;
				awready     <= 1'b0;
				pend_q.addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_q    <= 1'b1;
				wready      <= 1'b0;
				pend_q.data <= wdata;
				pend_q.strb <= wstrb;
			end
			if (aw_hold_q && w_hold_q && !bvalid) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				bvalid       <= 1'b1;
				bresp        <= reg_mapped(pend_q.addr) ? RESP_OKAY : RESP_SLVERR;
				wr_cmd       <= pend_q;
				wr_cmd.valid <= reg_mapped(pend_q.addr);
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read data is looked up at the address handshake and answered one cycle later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= reg_mapped(araddr) ? rd_data : 32'h0;
			rresp   <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule : axil_slave

// file: clkref_ctrl.sv
// Function
// RQ1: Mode 01 selects normal PLL operation.
// RQ2: Locked PLL replaces bypass as core clock.
// RQ3: Core clock is 11.2896 or 12.288 MHz.
// RQ4: Predivide codes 000-100 divide by 1-16.
// RQ5: Oscillator runs at reference times feedback divider.
// RQ6: Divider: 7 integer, 13 fraction bits.
// RQ7: Mode 10 enables frame clock tracking.
// RQ8: Rewriting integer divider resets the PLL.
// RQ9: Software retoggles tracking on rate family change.
// RQ10: References follow ACTIVE and STANDBY entry.
// RQ11: Quick-charge bit selects low-resistance charging path.
// RQ12: Timer holds reference users until settled.
// RQ13: Central bias enabled from reset, software controlled.
// RQ14: Local bias on when any sub-block enabled.
// RQ15: Pad range bit: 0 high, 1 low.
// RQ16: Mode 00 bypasses PLL with master clock.
// RQ17: Detected master clock feeds the PLL input.
// RQ18: Undefined mode 11 behaves as bypass.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module clkref_ctrl
	import clkref_pkg::*;
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	// AXI4-Lite write data
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	// AXI4-Lite write response
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// AXI4-Lite read address
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	// AXI4-Lite read data
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// Analog status pins
	input  wire logic                  mclk_detect_in,
	input  wire logic                  pll_lock_in,
	// PLL control
	output logic                       pll_enable_q,
	output logic                       pll_track_q,
	output logic                       pll_reset_q,
	output logic [2:0]                 predivide_code_q,
	output logic [4:0]                 predivide_factor_q,
	output logic [19:0]                fbdiv_value_q,
	output logic                       core_rate_48k_q,
	// Clock selection
	output logic                       core_clock_from_pll_q,
	output logic                       pll_input_from_mclk_q,
	output logic                       ref_osc_enable_q,
	// References and bias
	output logic                       vref_enable_q,
	output logic                       vmid_enable_q,
	output logic                       converter_reference_enable_q,
	output logic                       vmid_fast_charge_q,
	output logic                       vref_users_enable_q,
	output logic                       central_bias_enable_q,
	output logic [NUM_SUBSYS-1:0]      local_bias_enable_q,
	output logic [2*NUM_SUBSYS-1:0]    subblock_enable_q,
	// Pad supply range
	output logic                       io_low_voltage_q
);

	wr_cmd_type          wr_cmd;
	logic [31:0]         rd_data;
	logic [SYNC_W-1:0]   sync_s;
	logic                mclk_det_s;
	logic                lock_s;

	logic [5:0]          clk_ctrl_q;
	logic [6:0]          fbdiv_int_q;
	logic [4:0]          frac_top_q;
	logic [7:0]          frac_bot_q;
	logic [3:0]          ref_ctrl_q;
	logic [7:0]          subsys_en_q;

	pll_mode_type        mode;
	logic                pll_mode_on;
	logic                active_req;
	logic                wr_lane0;

	ref_state_type       ref_state_q;
	ref_state_type       ref_state_d;
	logic [TIMER_W-1:0]  timer_q;

	// Bus front end.
	axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_cmd  (wr_cmd),
		.rd_data (rd_data)
	);

	// Status pins from the analog side cross into the bus clock here.
	input_sync3 u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({pll_lock_in, mclk_detect_in}),
		.sync_out (sync_s)
	);

	assign mclk_det_s = sync_s[MCLK_IDX];
	assign lock_s     = sync_s[LOCK_IDX];
	assign wr_lane0   = wr_cmd.valid && wr_cmd.strb[0];
	assign active_req = ref_ctrl_q[ACTIVE_BIT];

	// Mode decode; code 11 is folded into bypass.
	always_comb begin
		case (clk_ctrl_q[MODE_LSB +: 2])
			2'b01:   mode = MODE_NORMAL; // RQ1
			2'b10:   mode = MODE_TRACK; // RQ7
			2'b00:   mode = MODE_BYPASS; // RQ16
			default: mode = MODE_BYPASS; // RQ18
		endcase
	end

	assign pll_mode_on = (mode == MODE_NORMAL) || (mode == MODE_TRACK);

	// Clock control register: mode, predivide select and rate family.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_ctrl_q <= CLK_CTRL_RST;
		end else if (wr_lane0 && wr_cmd.addr == CLK_CTRL_OFS) begin
			clk_ctrl_q <= wr_cmd.data[5:0];
		end
	end

	// Feedback divider registers: integer, upper fraction, lower fraction.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fbdiv_int_q <= FBDIV_INT_RST;
			frac_top_q  <= FRAC_TOP_RST;
			frac_bot_q  <= FRAC_BOT_RST;
		end else if (wr_lane0) begin
			if (wr_cmd.addr == FBDIV_INT_OFS) begin
				fbdiv_int_q <= wr_cmd.data[6:0]; // RQ6
			end
			if (wr_cmd.addr == FRAC_TOP_OFS) begin
				frac_top_q <= wr_cmd.data[4:0]; // RQ6
			end
			if (wr_cmd.addr == FRAC_BOT_OFS) begin
				frac_bot_q <= wr_cmd.data[7:0]; // RQ6
			end
		end
	end

	// Reference control register; the bias bit comes out of reset set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_ctrl_q <= REF_CTRL_RST; // RQ13
		end else if (wr_lane0 && wr_cmd.addr == REF_CTRL_OFS) begin
			ref_ctrl_q <= wr_cmd.data[3:0];
		end
	end

	// Sub-block enables, two per subsystem.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			subsys_en_q <= SUBSYS_EN_RST;
		end else if (wr_lane0 && wr_cmd.addr == SUBSYS_EN_OFS) begin
			subsys_en_q <= wr_cmd.data[7:0];
		end
	end

	// Any write to the integer divider with byte lane 0 enabled pulses the PLL reset for one cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_reset_q <= 1'b0;
		end else begin
			pll_reset_q <= wr_lane0 && (wr_cmd.addr == FBDIV_INT_OFS); // RQ8
		end
	end

	// PLL enable and tracking follow the decoded mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_enable_q <= 1'b0;
			pll_track_q  <= 1'b0;
		end else begin
			pll_enable_q <= pll_mode_on; // RQ1
			pll_track_q  <= (mode == MODE_TRACK); // RQ7 RQ9
		end
	end

	// Divider settings presented to the analog PLL.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			predivide_code_q   <= CLK_CTRL_RST[PREDIV_LSB +: 3];
			predivide_factor_q <= predivide_factor(CLK_CTRL_RST[PREDIV_LSB +: 3]);
			fbdiv_value_q      <= {FBDIV_INT_RST, FRAC_TOP_RST, FRAC_BOT_RST};
			core_rate_48k_q    <= CLK_CTRL_RST[RATE_BIT];
		end else begin
			predivide_code_q   <= clk_ctrl_q[PREDIV_LSB +: 3];
			predivide_factor_q <= predivide_factor(clk_ctrl_q[PREDIV_LSB +: 3]); // RQ4
			fbdiv_value_q      <= {fbdiv_int_q, frac_top_q, frac_bot_q}; // RQ5 RQ6
			core_rate_48k_q    <= clk_ctrl_q[RATE_BIT]; // RQ3
		end
	end

	// The PLL drives the core clock only while enabled and locked; a reset drops it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_clock_from_pll_q <= 1'b0;
		end else begin
			core_clock_from_pll_q <= pll_mode_on && lock_s && !pll_reset_q; // RQ2 RQ16 RQ18
		end
	end

	// Master clock feeds the PLL while detected; otherwise the oscillator runs when active.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_input_from_mclk_q <= 1'b0;
			ref_osc_enable_q      <= 1'b0;
		end else begin
			pll_input_from_mclk_q <= mclk_det_s; // RQ17
			ref_osc_enable_q      <= active_req && !mclk_det_s;
		end
	end

	// Reference sequencing state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_state_q <= REF_STANDBY;
		end else begin
			ref_state_q <= ref_state_d;
		end
	end

	always_comb begin
		ref_state_d = ref_state_q;
		case (ref_state_q)
			REF_STANDBY: begin
				if (active_req) begin
					ref_state_d = REF_CHARGING; // RQ10
				end
			end
			REF_CHARGING: begin
				if (!active_req) begin
					ref_state_d = REF_STANDBY; // RQ10
				end else if (timer_q == TIMER_W'(VREF_SETTLE_CYCLES - 1)) begin
					ref_state_d = REF_READY; // RQ12
				end
			end
			REF_READY: begin
				if (!active_req) begin
					ref_state_d = REF_STANDBY; // RQ10
				end
			end
			default: begin
				ref_state_d = REF_STANDBY;
			end
		endcase
	end

	// Settling timer counts only while charging.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_q <= '0;
		end else if (ref_state_q == REF_CHARGING && active_req) begin
			timer_q <= timer_q + TIMER_W'(1); // RQ12
		end else begin
			timer_q <= '0;
		end
	end

	// Reference enables and the gate for circuits that need the bandgap.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vref_enable_q                <= 1'b0;
			vmid_enable_q                <= 1'b0;
			converter_reference_enable_q <= 1'b0;
			vref_users_enable_q          <= 1'b0;
		end else begin
			vref_enable_q                <= (ref_state_d != REF_STANDBY); // RQ10
			vmid_enable_q                <= (ref_state_d != REF_STANDBY); // RQ10
			converter_reference_enable_q <= (ref_state_d != REF_STANDBY);
			vref_users_enable_q          <= (ref_state_d == REF_READY); // RQ12
		end
	end

	// Bias, quick charge, sub-block enables and pad range.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vmid_fast_charge_q    <= REF_CTRL_RST[FAST_BIT];
			central_bias_enable_q <= REF_CTRL_RST[BIAS_BIT];
			io_low_voltage_q      <= REF_CTRL_RST[IOLV_BIT];
			subblock_enable_q     <= SUBSYS_EN_RST;
			local_bias_enable_q   <= '0;
		end else begin
			vmid_fast_charge_q    <= ref_ctrl_q[FAST_BIT]; // RQ11
			central_bias_enable_q <= ref_ctrl_q[BIAS_BIT]; // RQ13
			io_low_voltage_q      <= ref_ctrl_q[IOLV_BIT]; // RQ15
			subblock_enable_q     <= subsys_en_q;
			for (int i = 0; i < NUM_SUBSYS; i++) begin
				local_bias_enable_q[i] <= |subsys_en_q[2*i +: 2]; // RQ14
			end
		end
	end

	// Read lookup for the bus front end.
	always_comb begin
		rd_data = 32'h0;
		case (araddr)
			CLK_CTRL_OFS:  rd_data[5:0] = clk_ctrl_q;
			FBDIV_INT_OFS: rd_data[6:0] = fbdiv_int_q;
			FRAC_TOP_OFS:  rd_data[4:0] = frac_top_q;
			FRAC_BOT_OFS:  rd_data[7:0] = frac_bot_q;
			REF_CTRL_OFS:  rd_data[3:0] = ref_ctrl_q;
			SUBSYS_EN_OFS: rd_data[7:0] = subsys_en_q;
			STATUS_OFS: begin
				rd_data[0]   = mclk_det_s; // RQ17
				rd_data[1]   = lock_s;
				rd_data[2]   = core_clock_from_pll_q;
				rd_data[3]   = pll_track_q;
				rd_data[4]   = vref_users_enable_q;
				rd_data[5]   = vref_enable_q;
				rd_data[7:6] = ref_state_q;
			end
			default:       rd_data = 32'h0;
		endcase
	end

endmodule : clkref_ctrl

// file: clkref_ctrl_sva.sv
// Assertion checker for the clock and reference control block.
`timescale 1ns/1ps
module clkref_ctrl_sva
	import clkref_pkg::*;
(
	// Clock and reset
	input wire logic                    aclk,
	input wire logic                    aresetn,
	// Observed outputs
	input wire logic                    pll_enable_q,
	input wire logic                    pll_track_q,
	input wire logic                    pll_reset_q,
	input wire logic [2:0]              predivide_code_q,
	input wire logic [4:0]              predivide_factor_q,
	input wire logic                    core_clock_from_pll_q,
	input wire logic                    pll_input_from_mclk_q,
	input wire logic                    ref_osc_enable_q,
	input wire logic                    vref_enable_q,
	input wire logic                    vmid_enable_q,
	input wire logic                    converter_reference_enable_q,
	input wire logic                    vref_users_enable_q,
	input wire logic [NUM_SUBSYS-1:0]   local_bias_enable_q,
	input wire logic [2*NUM_SUBSYS-1:0] subblock_enable_q
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Counts cycles since the references came on.
	logic [11:0] settle_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || !vref_enable_q) settle_q <= 12'h000;
		else settle_q <= settle_q + 12'h001;
	end

	property p_track_en; pll_track_q |-> pll_enable_q; endproperty
	a_track_en: assert property (p_track_en) else $error("tracking without pll");
	property p_bypass; (!pll_enable_q)[*2] |-> !core_clock_from_pll_q; endproperty
	a_bypass: assert property (p_bypass) else $error("pll clock used in bypass");
	property p_reset_drop; pll_reset_q |=> !pll_reset_q && !core_clock_from_pll_q; endproperty
	a_reset_drop: assert property (p_reset_drop) else $error("pll reset pulse wrong");
	property p_refs; vref_enable_q == vmid_enable_q && vmid_enable_q == converter_reference_enable_q; endproperty
	a_refs: assert property (p_refs) else $error("references disagree");
	property p_users; vref_users_enable_q |-> vref_enable_q; endproperty
	a_users: assert property (p_users) else $error("users on without reference");
	property p_settle; $rose(vref_users_enable_q) |-> settle_q == 12'(VREF_SETTLE_CYCLES); endproperty
	a_settle: assert property (p_settle) else $error("settle time wrong");
	property p_local;
		local_bias_enable_q == {|subblock_enable_q[7:6], |subblock_enable_q[5:4],
			|subblock_enable_q[3:2], |subblock_enable_q[1:0]};
	endproperty
	a_local: assert property (p_local) else $error("local bias mismatch");
	property p_prediv; predivide_factor_q == ((predivide_code_q > 3'h4) ? 5'h10 : 5'h01 << predivide_code_q); endproperty
	a_prediv: assert property (p_prediv) else $error("predivide factor wrong");
	property p_osc; ref_osc_enable_q |-> !pll_input_from_mclk_q; endproperty
	a_osc: assert property (p_osc) else $error("oscillator on with master clock");
endmodule : clkref_ctrl_sva

// file: tb_clkref_ctrl.sv
// Self-checking testbench for the clock and reference control block.
`timescale 1ns/1ps
module tb_clkref_ctrl
	import clkref_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mclk_detect_in, pll_lock_in;
	logic        awready, wready, bvalid, arready, rvalid, pll_enable_q, pll_track_q, pll_reset_q;
	logic        core_rate_48k_q, core_clock_from_pll_q, pll_input_from_mclk_q, ref_osc_enable_q;
	logic        vref_enable_q, vmid_enable_q, converter_reference_enable_q, vmid_fast_charge_q;
	logic        vref_users_enable_q, central_bias_enable_q, io_low_voltage_q;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [2:0]  predivide_code_q;
	logic [4:0]  predivide_factor_q;
	logic [19:0] fbdiv_value_q;
	logic [NUM_SUBSYS-1:0]   local_bias_enable_q;
	logic [2*NUM_SUBSYS-1:0] subblock_enable_q;
	int          failures, cmp_count, seed, i, n;

	initial aclk = 1'b0;
	always #2.5 aclk = ~aclk;

	clkref_ctrl clkref_ctrl_inst (.*);

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (bvalid) break;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		r = bresp;
		bready <= 1'b0;
		if (k == 40) begin
			failures++;
			print_verdict();
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (rvalid) break;
			if (arvalid && arready) arvalid <= 1'b0;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (k == 40) begin
			failures++;
			print_verdict();
		end
	endtask : axi_read

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, rs);
		check_val(32'(rs), 32'(RESP_OKAY));
	endtask : wr

	function automatic logic [4:0] exp_factor(input logic [2:0] c);
		exp_factor = (c >= 3'h4) ? 5'h10 : (c == 3'h3) ? 5'h08 : (c == 3'h2) ? 5'h04 : (c == 3'h1) ? 5'h02 : 5'h01;
	endfunction : exp_factor

	function automatic logic [3:0] exp_local(input logic [7:0] s);
		exp_local = {|s[7:6], |s[5:4], |s[3:2], |s[1:0]};
	endfunction : exp_local

	initial begin
		seed = 32'h4113;
		failures = 0;
		cmp_count = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
		{awaddr, araddr, wdata} <= 48'h0;
		wstrb <= 4'hf;
		mclk_detect_in <= 1'b1;
		pll_lock_in <= 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		check_val(32'(central_bias_enable_q), 32'h1);
		check_val(32'(fbdiv_value_q), 32'h40000);
		axi_read(REF_CTRL_OFS, rd, rs);
		check_val(rd, 32'h4);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			wr(CLK_CTRL_OFS, 32'(i));
			repeat (3) @(posedge aclk);
			check_val(32'(pll_enable_q), 32'(i == 1 || i == 2));
			check_val(32'(pll_track_q), 32'(i == 2));
			check_val(32'(core_clock_from_pll_q), 32'(i == 1 || i == 2));
			check_val(32'(pll_input_from_mclk_q), 32'h1);
		end
		$display("test modes done");
		for (i = 0; i < 8; i++) begin
			v = {26'h0, 1'($random(seed)), 3'(i), 2'b01};
			wr(CLK_CTRL_OFS, v);
			repeat (3) @(posedge aclk);
			check_val(32'(predivide_factor_q), 32'(exp_factor(3'(i))));
			check_val(32'(predivide_code_q), 32'(i));
			check_val(32'(core_rate_48k_q), 32'(v[5]));
		end
		$display("test predivide done");
		for (i = 0; i < 3; i++) begin
			v = (i == 0) ? 32'hfffff : 32'($random(seed));
			wr(FRAC_TOP_OFS, 32'(v[12:8]));
			wr(FRAC_BOT_OFS, 32'(v[7:0]));
			wr(FBDIV_INT_OFS, 32'(v[19:13]));
			n = 0;
			repeat (4) begin
				n += int'(pll_reset_q);
				@(posedge aclk);
			end
			check_val(32'(n), 32'h1);
			check_val(32'(fbdiv_value_q), 32'(v[19:0]));
		end
		$display("test divider done");
		pll_lock_in <= 1'b0;
		repeat (8) @(posedge aclk);
		check_val(32'(core_clock_from_pll_q), 32'h0);
		wr(CLK_CTRL_OFS, 32'h0);
		wr(FBDIV_INT_OFS, 32'h20);
		pll_lock_in <= 1'b1;
		wr(CLK_CTRL_OFS, 32'h2);
		repeat (8) @(posedge aclk);
		check_val(32'({core_clock_from_pll_q, pll_track_q}), 32'h3);
		mclk_detect_in <= 1'b0;
		repeat (8) @(posedge aclk);
		check_val(32'(pll_input_from_mclk_q), 32'h0);
		$display("test relock done");
		wr(REF_CTRL_OFS, 32'hb);
		for (i = 0; i < 2100 && vref_users_enable_q !== 1'b1; i++) @(posedge aclk);
		check_val(32'(i), 32'(VREF_SETTLE_CYCLES + 2));
		if (i == 2100) print_verdict();
		check_val(32'({vref_enable_q, vmid_enable_q, converter_reference_enable_q, vmid_fast_charge_q,
			io_low_voltage_q, central_bias_enable_q, ref_osc_enable_q}), 32'h7d);
		axi_read(STATUS_OFS, rd, rs);
		check_val(rd, 32'hbe);
		wr(REF_CTRL_OFS, 32'h4);
		repeat (3) @(posedge aclk);
		check_val(32'({vref_enable_q, vmid_enable_q, converter_reference_enable_q, vmid_fast_charge_q,
			io_low_voltage_q, central_bias_enable_q, ref_osc_enable_q, vref_users_enable_q}), 32'h04);
		$display("test references done");
		for (i = 0; i < 5; i++) begin
			v = (i == 0) ? 32'h81 : 32'($random(seed));
			wr(SUBSYS_EN_OFS, v);
			repeat (3) @(posedge aclk);
			check_val(32'(local_bias_enable_q), 32'(exp_local(v[7:0])));
			check_val(32'(subblock_enable_q), 32'(v[7:0]));
		end
		$display("test bias done");
		axi_write(8'h1c, 32'h1, rs);
		check_val(32'(rs), 32'(RESP_SLVERR));
		axi_read(8'h02, rd, rs);
		check_val({rd[29:0], rs}, 32'(RESP_SLVERR));
		$display("test unmapped done");
		print_verdict();
	end
endmodule : tb_clkref_ctrl

bind clkref_ctrl clkref_ctrl_sva clkref_ctrl_sva_inst (.*);
